/* rtl/cmb_field_codec.sv */
// Purpose: packs frame fields into header words and unpacks header words into fields
// Assumes: purely combinational, used by the sequencer on both paths
// Notes:   payload byte 0 sits in the low byte of word 3
`timescale 1ns/1ps
module cmb_field_codec
  import cmb_pkg::*;
(
  // words to unpack
  input  wire logic [cmb_pkg::HDR_W-1:0] words_in,
  // unpacked fields
  output logic [10:0]                    std_ident_out,
  output logic                           subst_remote_out,
  output logic                           ext_fmt_out,
  output logic [17:0]                    ext_ident_out,
  output logic                           remote_out,
  output logic                           rsv_high_out,
  output logic                           rsv_low_out,
  output logic [3:0]                     len_out,
  output logic [3:0]                     payload_len_out,
  output logic [7:0]                     byte0_out,
  output logic [7:0]                     byte1_out,
  // fields to pack
  input  wire logic [10:0]               std_ident_in,
  input  wire logic                      subst_remote_in,
  input  wire logic                      ext_fmt_in,
  input  wire logic [17:0]               ext_ident_in,
  input  wire logic                      remote_in,
  input  wire logic                      rsv_high_in,
  input  wire logic                      rsv_low_in,
  input  wire logic [3:0]                len_in,
  input  wire logic [7:0]                byte0_in,
  input  wire logic [7:0]                byte1_in,
  // packed words
  output logic [cmb_pkg::HDR_W-1:0]      words_out
);
  import cmb_pkg::*;

  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [15:0] w3;

  // ---------------------------------------------------------------
  // unpack
  // ---------------------------------------------------------------
  always_comb begin
    w0 = words_in[15:0];
    w1 = words_in[31:16];
    w2 = words_in[47:32];
    w3 = words_in[63:48];
    std_ident_out    = w0[STD_IDENT_MSB:STD_IDENT_LSB];
    subst_remote_out = w0[SUBST_RMT_BIT];
    ext_fmt_out      = w0[EXT_FMT_BIT];
    // standard frames carry no extension, so hide it from the protocol engine
    ext_ident_out    = w0[EXT_FMT_BIT] ? {w1[EXT_HI_MSB:0], w2[15:EXT_LO_LSB]} : 18'h0;
    remote_out       = w2[RMT_REQ_BIT];
    rsv_high_out     = w2[RSV_HIGH_BIT];
    rsv_low_out      = w2[RSV_LOW_BIT];
    len_out          = w2[LEN_MSB:0];
    payload_len_out  = w2[RMT_REQ_BIT] ? 4'h0 : w2[LEN_MSB:0];
    byte0_out        = w3[BYTE0_LSB +: 8];
    byte1_out        = w3[BYTE1_LSB +: 8];
  end

  // ---------------------------------------------------------------
  // pack, same layout as software uses
  // ---------------------------------------------------------------
  always_comb begin
    words_out = {byte1_in, byte0_in,
                 ext_ident_in[5:0], remote_in, rsv_high_in, 3'h0, rsv_low_in, len_in,
                 4'h0, ext_ident_in[17:6],
                 3'h0, std_ident_in, subst_remote_in, ext_fmt_in};
  end

endmodule

/* rtl/cmb_msg_buf_engine.sv */
// Purpose: fetches transmit headers from and stores receive headers to shared RAM buffers
// Assumes: ram port on core_clk_in; a request stands until ram_ack_in, read data with ack
// Notes:   four words per buffer; buffer n starts at area_base_in + 4*n
`timescale 1ns/1ps
module cmb_msg_buf_engine
  import cmb_pkg::*;
(
  // clock and reset
  input  wire logic                           core_clk_in,
  input  wire logic                           reset_in,
  // buffer area set up by software
  input  wire logic [cmb_pkg::RAM_ADDR_W-1:0] area_base_in,
  input  wire logic [cmb_pkg::BUF_CNT_W-1:0]  area_bufs_in,
  // transmit fetch
  input  wire logic                           tx_req_in,
  input  wire logic [cmb_pkg::BUF_IDX_W-1:0]  tx_buf_in,
  output logic                                tx_valid_out,
  output logic [10:0]                         tx_std_ident_out,
  output logic                                tx_subst_remote_out,
  output logic                                tx_ext_fmt_out,
  output logic [17:0]                         tx_ext_ident_out,
  output logic                                tx_remote_out,
  output logic                                tx_rsv_high_out,
  output logic                                tx_rsv_low_out,
  output logic [3:0]                          tx_len_out,
  output logic [3:0]                          tx_payload_len_out,
  output logic [7:0]                          tx_byte0_out,
  output logic [7:0]                          tx_byte1_out,
  // receive store
  input  wire logic                           rx_req_in,
  input  wire logic [cmb_pkg::BUF_IDX_W-1:0]  rx_buf_in,
  input  wire logic [10:0]                    rx_std_ident_in,
  input  wire logic                           rx_subst_remote_in,
  input  wire logic                           rx_ext_fmt_in,
  input  wire logic [17:0]                    rx_ext_ident_in,
  input  wire logic                           rx_remote_in,
  input  wire logic                           rx_rsv_high_in,
  input  wire logic                           rx_rsv_low_in,
  input  wire logic [3:0]                     rx_len_in,
  input  wire logic [7:0]                     rx_byte0_in,
  input  wire logic [7:0]                     rx_byte1_in,
  output logic                                rx_done_out,
  // status
  output logic                                busy_out,
  output logic                                range_err_out,
  // shared ram port
  output logic [cmb_pkg::RAM_ADDR_W-1:0]      ram_addr_out,
  output logic                                ram_rd_out,
  output logic                                ram_wr_out,
  output logic [cmb_pkg::WORD_W-1:0]          ram_wdata_out,
  input  wire logic [cmb_pkg::WORD_W-1:0]     ram_rdata_in,
  input  wire logic                           ram_ack_in
);
  import cmb_pkg::*;

  cmb_regs_s         state_reg;
  cmb_regs_s         state_next;
  logic [HDR_W-1:0]  rx_words;
  logic              tx_in_area;
  logic              rx_in_area;
  logic              rx_accept;

  // ---------------------------------------------------------------
  // field codec
  // ---------------------------------------------------------------
  cmb_field_codec u_codec (
    .words_in         (state_reg.words),
    .std_ident_out    (tx_std_ident_out),
    .subst_remote_out (tx_subst_remote_out),
    .ext_fmt_out      (tx_ext_fmt_out),
    .ext_ident_out    (tx_ext_ident_out),
    .remote_out       (tx_remote_out),
    .rsv_high_out     (tx_rsv_high_out),
    .rsv_low_out      (tx_rsv_low_out),
    .len_out          (tx_len_out),
    .payload_len_out  (tx_payload_len_out),
    .byte0_out        (tx_byte0_out),
    .byte1_out        (tx_byte1_out),
    .std_ident_in     (rx_std_ident_in),
    .subst_remote_in  (rx_subst_remote_in),
    .ext_fmt_in       (rx_ext_fmt_in),
    .ext_ident_in     (rx_ext_ident_in),
    .remote_in        (rx_remote_in),
    .rsv_high_in      (rx_rsv_high_in),
    .rsv_low_in       (rx_rsv_low_in),
    .len_in           (rx_len_in),
    .byte0_in         (rx_byte0_in),
    .byte1_in         (rx_byte1_in),
    .words_out        (rx_words)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign tx_in_area = {1'b0, tx_buf_in} < area_bufs_in;
  assign rx_in_area = {1'b0, rx_buf_in} < area_bufs_in;
  // transmit wins when both ask in the same cycle; receive waits
  assign rx_accept  = (state_reg.st == CMB_IDLE) && !tx_req_in && rx_req_in && rx_in_area;

  always_comb begin
    state_next          = state_reg;
    state_next.tx_valid = 1'b0;
    state_next.rx_done  = 1'b0;
    state_next.err      = 1'b0;
    unique case (state_reg.st)
      CMB_IDLE: begin
        if (tx_req_in) begin
          if (tx_in_area) begin
            state_next.st       = CMB_FETCH;
            state_next.widx     = 2'h0;
            state_next.buf_addr = area_base_in + {9'h0, tx_buf_in, 2'b00};
            state_next.ram_rd   = 1'b1;
          end else begin
            state_next.err = 1'b1;
          end
        end else if (rx_req_in) begin
          if (rx_in_area) begin
            state_next.st       = CMB_STORE;
            state_next.widx     = 2'h0;
            state_next.words    = rx_words;
            state_next.buf_addr = area_base_in + {9'h0, rx_buf_in, 2'b00};
            state_next.ram_wr   = 1'b1;
          end else begin
            state_next.err = 1'b1;
          end
        end
      end
      CMB_FETCH: begin
        if (ram_ack_in) begin
          // unimplemented bits are dropped so they always read as zero
          state_next.words[{state_reg.widx, 4'h0} +: 16] =
            ram_rdata_in & ~cmb_unimpl_mask(state_reg.widx);
          if (state_reg.widx == 2'h3) begin
            state_next.ram_rd   = 1'b0;
            state_next.st       = CMB_IDLE;
            state_next.tx_valid = 1'b1;
          end else begin
            state_next.widx = state_reg.widx + 2'h1;
          end
        end
      end
      CMB_STORE: begin
        if (ram_ack_in) begin
          if (state_reg.widx == 2'h3) begin
            state_next.ram_wr  = 1'b0;
            state_next.st      = CMB_IDLE;
            state_next.rx_done = 1'b1;
          end else begin
            state_next.widx = state_reg.widx + 2'h1;
          end
        end
      end
      default: begin
        state_next.st     = CMB_IDLE;
        state_next.ram_rd = 1'b0;
        state_next.ram_wr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg          <= '0;
      state_reg.st       <= CMB_IDLE;
      state_reg.words    <= WORDS_RESET;
      state_reg.buf_addr <= ADDR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ram_addr_out  = state_reg.buf_addr + {14'h0, state_reg.widx};
  assign ram_rd_out    = state_reg.ram_rd;
  assign ram_wr_out    = state_reg.ram_wr;
  assign ram_wdata_out = state_reg.words[{state_reg.widx, 4'h0} +: 16];
  assign tx_valid_out  = state_reg.tx_valid;
  assign rx_done_out   = state_reg.rx_done;
  assign range_err_out = state_reg.err;
  assign busy_out      = state_reg.st != CMB_IDLE;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_in_area;
    @(posedge core_clk_in) disable iff (reset_in)
      (ram_rd_out || ram_wr_out) |-> (ram_addr_out >= area_base_in);
  endproperty
  a_in_area: assert property (p_in_area) else $error("ram access below buffer area");

  property p_fetch_ends;
    @(posedge core_clk_in) disable iff (reset_in)
      (state_reg.st == CMB_FETCH && ram_ack_in && state_reg.widx == 2'h3)
        |=> (tx_valid_out && !ram_rd_out && !busy_out);
  endproperty
  a_fetch_ends: assert property (p_fetch_ends) else $error("fetch did not end after word 3");

  property p_std_store;
    @(posedge core_clk_in) disable iff (reset_in)
      rx_accept |=> state_reg.words[12:2] == $past(rx_std_ident_in);
  endproperty
  a_std_store: assert property (p_std_store) else $error("standard ident misplaced");

  property p_subst_store;
    @(posedge core_clk_in) disable iff (reset_in)
      rx_accept |=> state_reg.words[1] == $past(rx_subst_remote_in);
  endproperty
  a_subst_store: assert property (p_subst_store) else $error("substitute flag misplaced");

  property p_std_only;
    @(posedge core_clk_in) disable iff (reset_in)
      (tx_valid_out && !tx_ext_fmt_out) |-> tx_ext_ident_out == 18'h0;
  endproperty
  a_std_only: assert property (p_std_only) else $error("extension sent on standard frame");

  property p_ext_split;
    @(posedge core_clk_in) disable iff (reset_in)
      rx_accept |=> {state_reg.words[27:16], state_reg.words[47:42]} == $past(rx_ext_ident_in);
  endproperty
  a_ext_split: assert property (p_ext_split) else $error("extended ident misplaced");

  property p_unimpl_zero;
    @(posedge core_clk_in) disable iff (reset_in)
      ram_wr_out |-> (ram_wdata_out & cmb_unimpl_mask(state_reg.widx)) == 16'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit written");

  property p_len_store;
    @(posedge core_clk_in) disable iff (reset_in)
      rx_accept |=> state_reg.words[35:32] == $past(rx_len_in);
  endproperty
  a_len_store: assert property (p_len_store) else $error("length code misplaced");

  property p_bytes_store;
    @(posedge core_clk_in) disable iff (reset_in)
      rx_accept |=> state_reg.words[63:48] == {$past(rx_byte1_in), $past(rx_byte0_in)};
  endproperty
  a_bytes_store: assert property (p_bytes_store) else $error("payload bytes misplaced");

  property p_remote_empty;
    @(posedge core_clk_in) disable iff (reset_in)
      (tx_valid_out && tx_remote_out) |-> tx_payload_len_out == 4'h0;
  endproperty
  a_remote_empty: assert property (p_remote_empty) else $error("remote frame with payload");

  property p_store_layout;
    @(posedge core_clk_in) disable iff (reset_in)
      (rx_accept ##1 (ram_wr_out && ram_ack_in)) |-> ram_addr_out == state_reg.buf_addr;
  endproperty
  a_store_layout: assert property (p_store_layout) else $error("store not starting at word 0");

endmodule

/* rtl/cmb_pkg.sv */
// Purpose: shared constants and types of the message buffer engine
// Assumes: buffers are 16-bit words in the shared DMA RAM, four words per buffer header
// Notes:   word i of a header travels in bits [16*i+15:16*i] of a 64-bit bundle
package cmb_pkg;

  // ---------------------------------------------------------------
  // buffer layout
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned HDR_WORDS      = 4;
  localparam int unsigned HDR_W          = WORD_W * HDR_WORDS;
  localparam int unsigned RAM_ADDR_W     = 16;
  localparam int unsigned BUF_IDX_W      = 5;
  localparam int unsigned BUF_CNT_W      = 6;
  // word 0
  localparam int unsigned STD_IDENT_LSB  = 2;
  localparam int unsigned STD_IDENT_MSB  = 12;
  localparam int unsigned SUBST_RMT_BIT  = 1;
  localparam int unsigned EXT_FMT_BIT    = 0;
  // word 1 and word 2
  localparam int unsigned EXT_HI_MSB     = 11;
  localparam int unsigned EXT_LO_LSB     = 10;
  localparam int unsigned RMT_REQ_BIT    = 9;
  localparam int unsigned RSV_HIGH_BIT   = 8;
  localparam int unsigned RSV_LOW_BIT    = 4;
  localparam int unsigned LEN_MSB        = 3;
  // word 3
  localparam int unsigned BYTE0_LSB      = 0;
  localparam int unsigned BYTE1_LSB      = 8;
  // unimplemented bits of each word, forced to zero
  localparam logic [15:0] WORD0_UNIMPL   = 16'he000;
  localparam logic [15:0] WORD1_UNIMPL   = 16'hf000;
  localparam logic [15:0] WORD2_UNIMPL   = 16'h00e0;
  localparam logic [15:0] WORD3_UNIMPL   = 16'h0000;
  // reset values
  localparam logic [63:0] WORDS_RESET    = 64'h0;
  localparam logic [15:0] ADDR_RESET     = 16'h0;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMB_IDLE  = 2'b00,
    CMB_FETCH = 2'b01,
    CMB_STORE = 2'b10
  } cmb_state_e;

  typedef struct packed {
    cmb_state_e  st;
    logic [1:0]  widx;
    logic [63:0] words;
    logic [15:0] buf_addr;
    logic        ram_rd;
    logic        ram_wr;
    logic        tx_valid;
    logic        rx_done;
    logic        err;
  } cmb_regs_s;

  // mask of unimplemented bits for a header word
  function automatic logic [15:0] cmb_unimpl_mask(input logic [1:0] idx);
    case (idx)
      2'h0:    cmb_unimpl_mask = WORD0_UNIMPL;
      2'h1:    cmb_unimpl_mask = WORD1_UNIMPL;
      2'h2:    cmb_unimpl_mask = WORD2_UNIMPL;
      default: cmb_unimpl_mask = WORD3_UNIMPL;
    endcase
  endfunction

endpackage

/* sim/cmb_msg_buf_engine_tb_top.sv */
// Purpose: self-checking bench of the message buffer engine
// Assumes: buffer area fits the 1024-word ram model
// Notes:   driver queues expectations, a monitor checks them on each result pulse
`timescale 1ns/1ps
module cmb_msg_buf_engine_tb_top;
  import cmb_pkg::*;
  logic        core_clk_in, reset_in, tx_req_in, rx_req_in, tx_valid_out, rx_done_out;
  logic        busy_out, range_err_out, ram_rd_out, ram_wr_out, ram_ack_in;
  logic        tx_subst_remote_out, tx_ext_fmt_out, tx_remote_out, tx_rsv_high_out;
  logic        tx_rsv_low_out, rx_subst_remote_in, rx_ext_fmt_in, rx_remote_in;
  logic        rx_rsv_high_in, rx_rsv_low_in;
  logic [1:0]  stall;
  logic [3:0]  tx_len_out, tx_payload_len_out, rx_len_in;
  logic [4:0]  tx_buf_in, rx_buf_in;
  logic [5:0]  area_bufs_in;
  logic [7:0]  tx_byte0_out, tx_byte1_out, rx_byte0_in, rx_byte1_in;
  logic [10:0] tx_std_ident_out, rx_std_ident_in;
  logic [15:0] area_base_in, ram_addr_out, ram_wdata_out, ram_rdata_in, a_v;
  logic [17:0] tx_ext_ident_out, rx_ext_ident_in;
  logic [65:0] exp_v, got_v;
  logic [65:0] q [$];
  logic [15:0] aq [$];
  int          fail_count, checks, cyc;

  cmb_msg_buf_engine dut_u (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .area_base_in(area_base_in),
    .area_bufs_in(area_bufs_in), .tx_req_in(tx_req_in), .tx_buf_in(tx_buf_in),
    .tx_valid_out(tx_valid_out), .tx_std_ident_out(tx_std_ident_out),
    .tx_subst_remote_out(tx_subst_remote_out), .tx_ext_fmt_out(tx_ext_fmt_out),
    .tx_ext_ident_out(tx_ext_ident_out), .tx_remote_out(tx_remote_out),
    .tx_rsv_high_out(tx_rsv_high_out), .tx_rsv_low_out(tx_rsv_low_out),
    .tx_len_out(tx_len_out), .tx_payload_len_out(tx_payload_len_out),
    .tx_byte0_out(tx_byte0_out), .tx_byte1_out(tx_byte1_out), .rx_req_in(rx_req_in),
    .rx_buf_in(rx_buf_in), .rx_std_ident_in(rx_std_ident_in),
    .rx_subst_remote_in(rx_subst_remote_in), .rx_ext_fmt_in(rx_ext_fmt_in),
    .rx_ext_ident_in(rx_ext_ident_in), .rx_remote_in(rx_remote_in),
    .rx_rsv_high_in(rx_rsv_high_in), .rx_rsv_low_in(rx_rsv_low_in),
    .rx_len_in(rx_len_in), .rx_byte0_in(rx_byte0_in), .rx_byte1_in(rx_byte1_in),
    .rx_done_out(rx_done_out), .busy_out(busy_out), .range_err_out(range_err_out),
    .ram_addr_out(ram_addr_out), .ram_rd_out(ram_rd_out), .ram_wr_out(ram_wr_out),
    .ram_wdata_out(ram_wdata_out), .ram_rdata_in(ram_rdata_in), .ram_ack_in(ram_ack_in)
  );

  cmb_ram_model ram_u (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .stall_in(stall),
    .ram_addr_in(ram_addr_out), .ram_rd_in(ram_rd_out), .ram_wr_in(ram_wr_out),
    .ram_wdata_in(ram_wdata_out), .ram_rdata_out(ram_rdata_in), .ram_ack_out(ram_ack_in)
  );

  initial core_clk_in = 1'b0;
  always #5 core_clk_in = ~core_clk_in;

  task cmp(input logic [65:0] e, input logic [65:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task results;
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task wait_idle;
    @(negedge core_clk_in);
    while (busy_out !== 1'b0) begin
      @(negedge core_clk_in);
    end
  endtask

  // also scrambles the fields after taking: they must be sampled once only
  task rand_rx;
    {rx_std_ident_in, rx_subst_remote_in, rx_ext_fmt_in, rx_ext_ident_in, rx_remote_in,
     rx_rsv_high_in, rx_rsv_low_in, rx_len_in, rx_byte0_in, rx_byte1_in}
      = 54'({$urandom, $urandom});
  endtask

  // mode 0 fetch, 1 store, 2 both in one cycle (fetch goes first)
  task start(input int mode, input logic [4:0] idx);
    logic [15:0] a, w0, w1, w2, w3;
    wait_idle();
    stall = 2'($urandom_range(0, 2));
    a = area_base_in + {9'h0, idx, 2'h0};
    if (idx >= area_bufs_in) begin
      q.push_back({2'd2, 64'h0});
    end
    if (mode != 1) begin
      {w0, w1, w2, w3} = {$urandom, $urandom};
      w2 &= 16'hfeef;
      ram_u.mem[a[9:0]] = w0;
      ram_u.mem[a[9:0] + 10'd1] = w1;
      ram_u.mem[a[9:0] + 10'd2] = w2;
      ram_u.mem[a[9:0] + 10'd3] = w3;
      if (idx < area_bufs_in) begin
        q.push_back({2'd0, 6'h0, w0[12:2], w0[1], w0[0],
                     w0[0] ? {w1[11:0], w2[15:10]} : 18'h0, w2[9], w2[8], w2[4], w2[3:0],
                     w2[9] ? 4'h0 : w2[3:0], w3[7:0], w3[15:8]});
      end
    end
    if (mode != 0) begin
      rand_rx();
      rx_rsv_high_in = 1'b0;
      rx_rsv_low_in  = 1'b0;
      if (idx < area_bufs_in) begin
        q.push_back({2'd1, 3'h0, rx_std_ident_in, rx_subst_remote_in, rx_ext_fmt_in, 4'h0,
                     rx_ext_ident_in, rx_remote_in, rx_rsv_high_in, 3'h0, rx_rsv_low_in,
                     rx_len_in, rx_byte1_in, rx_byte0_in});
        aq.push_back(a);
      end
    end
    tx_req_in = (mode != 1);
    rx_req_in = (mode != 0);
    tx_buf_in = idx;
    rx_buf_in = idx;
    @(negedge core_clk_in);
    tx_req_in = 1'b0;
    if (mode == 2) begin
      wait_idle();
      @(negedge core_clk_in);
    end
    rx_req_in = 1'b0;
    rand_rx();
  endtask

  // look a little after the edge: pulses and ram words have settled, and the
  // negedge driver has not yet refilled a buffer for the next request
  always @(posedge core_clk_in) begin
    #2;
    if (reset_in === 1'b0 && (tx_valid_out | rx_done_out | range_err_out) === 1'b1) begin
      exp_v = (q.size() != 0) ? q.pop_front() : '1;
      if (tx_valid_out) begin
        got_v = {2'd0, 6'h0, tx_std_ident_out, tx_subst_remote_out, tx_ext_fmt_out,
                 tx_ext_ident_out, tx_remote_out, tx_rsv_high_out, tx_rsv_low_out,
                 tx_len_out, tx_payload_len_out, tx_byte0_out, tx_byte1_out};
      end else if (rx_done_out) begin
        a_v = aq.pop_front();
        got_v = {2'd1, ram_u.mem[a_v[9:0]], ram_u.mem[a_v[9:0] + 10'd1],
                 ram_u.mem[a_v[9:0] + 10'd2], ram_u.mem[a_v[9:0] + 10'd3]};
      end else begin
        got_v = {2'd2, 61'h0, ram_rd_out, ram_wr_out, busy_out};
      end
      cmp(exp_v, got_v);
    end
  end

  // whole run is about a thousand cycles
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    int         m, k;
    logic [4:0] idx;
    void'($urandom(34));
    {tx_req_in, rx_req_in, tx_buf_in, rx_buf_in, stall} = '0;
    area_base_in = 16'h0;
    area_bufs_in = 6'h0;
    rand_rx();
    reset_in = 1'b1;
    repeat (12) @(posedge core_clk_in);
    @(negedge core_clk_in);
    reset_in = 1'b0;
    cmp(66'h0, 66'({tx_valid_out, rx_done_out, range_err_out, busy_out, ram_rd_out,
                    ram_wr_out, ram_addr_out}));
    for (int p = 0; p < 2; p++) begin
      // the area may only move while no buffer access is in flight
      wait_idle();
      area_base_in = 16'($urandom_range(0, 512));
      area_bufs_in = 6'($urandom_range(8, 31));
      for (int i = 0; i < 50; i++) begin
        m = $urandom_range(0, 2);
        k = $urandom_range(0, 7);
        idx = (k == 0 && m != 2) ? area_bufs_in[4:0] :
              (k == 1) ? area_bufs_in[4:0] - 5'h1 :
              5'($urandom_range(0, area_bufs_in - 1));
        start(m, idx);
      end
    end
    wait_idle();
    repeat (3) @(negedge core_clk_in);
    if (q.size() != 0) begin
      fail_count++;
    end
    results();
  end
endmodule

/* sim/cmb_ram_model.sv */
// Purpose: shared ram partner that answers the engine's word requests
// Assumes: one ack per word, given once stall_in idle cycles have passed
// Notes:   read data outside an ack is the inverted word, so a stale value cannot pass
`timescale 1ns/1ps
module cmb_ram_model
  import cmb_pkg::*;
(
  // clock and reset
  input  wire logic                           core_clk_in,
  input  wire logic                           reset_in,
  // idle cycles before each ack
  input  wire logic [1:0]                     stall_in,
  // ram port
  input  wire logic [cmb_pkg::RAM_ADDR_W-1:0] ram_addr_in,
  input  wire logic                           ram_rd_in,
  input  wire logic                           ram_wr_in,
  input  wire logic [cmb_pkg::WORD_W-1:0]     ram_wdata_in,
  output logic [cmb_pkg::WORD_W-1:0]          ram_rdata_out,
  output logic                                ram_ack_out
);
  logic [15:0] mem [0:1023];
  logic [1:0]  wait_reg;
  logic        req;

  assign req           = ram_rd_in | ram_wr_in;
  assign ram_ack_out   = req && (wait_reg >= stall_in);
  assign ram_rdata_out = (ram_ack_out && ram_rd_in) ? mem[ram_addr_in[9:0]]
                                                    : ~mem[ram_addr_in[9:0]];

  always_ff @(posedge core_clk_in) begin
    if (reset_in || !req || ram_ack_out) begin
      wait_reg <= 2'h0;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end

  // plain always: the bench also fills buffers here, as software would
  always @(posedge core_clk_in) begin
    if (ram_wr_in && ram_ack_out) begin
      mem[ram_addr_in[9:0]] <= ram_wdata_in;
    end
  end
endmodule
